// >>> rlcu_core_model.sv
`timescale 1ns/1ns
`default_nettype none

// ********************************************************
// core side: working registers and data memory
// ********************************************************
module rlcu_core_model
    import rlcu_pkg::*;
(
    input  wire logic [3:0] reg_s_idx,   // source index
    input  wire logic [3:0] reg_d_idx,   // destination index
    input  wire logic       mem_rd_en,   // read strobe
    input  wire rlcu_word_t mem_rd_addr, // read address
    output rlcu_word_t      reg_s_val,   // source contents
    output rlcu_word_t      reg_d_val,   // destination contents
    output rlcu_word_t      mem_rd_data  // read data
);
    rlcu_word_t regs [16];
    rlcu_word_t mem  [8192];
    rlcu_word_t last_val;

    // register file reads in the same cycle
    assign reg_s_val = regs[reg_s_idx];
    assign reg_d_val = regs[reg_d_idx];

    // unselected memory shows the inverse of the last word, so a design
    // that samples without its strobe cannot get the right value by luck
    always @(mem_rd_en or mem_rd_addr)
    begin
        if (mem_rd_en)
        begin
            mem_rd_data = mem[mem_rd_addr[12:0]];
            last_val    = mem_rd_data;
        end
        else
            mem_rd_data = ~last_val;
    end
endmodule : rlcu_core_model

`default_nettype wire

// >>> rlcu_pkg.sv
// ********************************************************
// shared types
// ********************************************************
package rlcu_pkg;
    typedef logic [2:0]  rlcu_amode_t;
    typedef logic [15:0] rlcu_word_t;
    typedef enum logic [1:0] {
        RLCU_FORM_NONE,
        RLCU_FORM_FILE,
        RLCU_FORM_WFORM
    } rlcu_form_t;
endpackage : rlcu_pkg

// >>> rlcu_regs.svh
`ifndef RLCU_REGS_SVH
`define RLCU_REGS_SVH

// ********************************************************
// instruction word fields
// ********************************************************
`define RLCU_F_OPHI     23:20
`define RLCU_F_OPLO     19:16
`define RLCU_F_SEL      15
`define RLCU_F_BYTE     14
`define RLCU_F_DEST     13
`define RLCU_F_FADDR    12:0
`define RLCU_F_DMODE    13:11
`define RLCU_F_DREG     10:7
`define RLCU_F_SMODE    6:4
`define RLCU_F_SREG     3:0

// ********************************************************
// opcode values
// ********************************************************
`define RLCU_OPC_HI     4'hD
`define RLCU_OPC_FILE   4'h6
`define RLCU_OPC_WFORM  4'h2
`define RLCU_OPC_SEL    1'h1
`define RLCU_WIDTH_BYTE 1'h1
`define RLCU_DEST_DEFW  1'h1
`define RLCU_DEFW_IDX   4'h0
`define RLCU_FADDR_PAD  3'h0

// ********************************************************
// status word bit positions and reset value
// ********************************************************
`define RLCU_SR_C       0
`define RLCU_SR_Z       1
`define RLCU_SR_N       3
`define RLCU_SR_RST     16'h0000
`define RLCU_FLAG_MASK  16'h000B

// ********************************************************
// addressing modes and pointer steps
// ********************************************************
`define RLCU_AM_DIR     3'h0
`define RLCU_AM_IND     3'h1
`define RLCU_AM_POSTDEC 3'h2
`define RLCU_AM_POSTINC 3'h3
`define RLCU_AM_PREDEC  3'h4
`define RLCU_AM_PREINC  3'h5
`define RLCU_STEP_BYTE  16'h0001
`define RLCU_STEP_WORD  16'h0002

`endif

// >>> rlcu_rotator.sv
`timescale 1ns/1ns
`default_nettype none

// ********************************************************
// rotate one position left through carry, byte or word
// ********************************************************
module rlcu_rotator
    import rlcu_pkg::*;
#(
    parameter int W = 16                // word width
)
(
    input  wire logic [W-1:0] opnd,     // operand value
    input  wire logic         carry_in, // carry before rotation
    input  wire logic         byte_sel, // high selects byte width
    output logic      [W-1:0] result,   // rotated value
    output logic              carry_out,// new carry
    output logic              neg,      // result sign for width
    output logic              zero      // result zero for width
);
    logic [W-1:0] word_rot;
    logic [7:0]   byte_rot;

    // carry enters at bit 0, everything moves one place up
    assign word_rot = {opnd[W-2:0], carry_in};                 // RL1
    assign byte_rot = {opnd[6:0], carry_in};                   // RL1

    // upper byte passes untouched in byte width; the core masks
    // the write with its byte enable anyway
    always_comb
    begin
        if (byte_sel)                                          // RL5
        begin
            result    = {opnd[W-1:8], byte_rot};
            carry_out = opnd[7];                               // RL2
            neg       = byte_rot[7];                           // RL13
            zero      = (byte_rot == 8'h00);                   // RL13
        end
        else
        begin
            result    = word_rot;
            carry_out = opnd[W-1];                             // RL2
            neg       = word_rot[W-1];                         // RL13
            zero      = (word_rot == {W{1'b0}});               // RL13
        end
    end
endmodule : rlcu_rotator

`default_nettype wire

// >>> rlcu_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rlcu_regs.svh"

// Function
// (RL1) shift up, old carry into bit 0
// (RL2) carry takes old top bit of width
// (RL3) file form writes default register or back
// (RL4) destination bit: 0 file, 1 default register
// (RL5) width bit: 0 word, 1 byte
// (RL6) file form decoded by 1101 0110 1
// (RL7) file address is 13 bits wide
// (RL8) register form decoded by 1101 0010 1
// (RL9) only negative, zero, carry change
// (RL10) one word, one cycle
// (RL11) byte suffix sets width bit
// (RL12) rotate uses carry from status word
// (RL13) negative from top bit, zero on zero
// (RL14) direct, indirect, pre/post inc/dec modes
module rlcu_top
    import rlcu_pkg::*;
(
    input  wire logic        clk,           // core clock
    input  wire logic        arst_n,        // async reset, low
    input  wire logic        instr_valid,   // instruction issued
    input  wire logic [23:0] instr_word,    // instruction word
    input  wire rlcu_word_t  sr_in,         // status_register_word now
    input  wire rlcu_word_t  reg_s_val,     // source register contents
    input  wire rlcu_word_t  reg_d_val,     // destination reg contents
    input  wire rlcu_word_t  mem_rd_data,   // data memory read value
    output logic      [3:0]  reg_s_idx,     // source register index
    output logic      [3:0]  reg_d_idx,     // destination reg index
    output logic             mem_rd_en,     // data memory read strobe
    output rlcu_word_t       mem_rd_addr,   // data memory read address
    output logic             done_q,        // instruction retired
    output logic             wr_byte_q,     // write is byte wide
    output rlcu_word_t       wr_data_q,     // result value
    output logic             wr_reg_en_q,   // register write
    output logic      [3:0]  wr_reg_idx_q,  // register written
    output logic             wr_mem_en_q,   // data memory write
    output rlcu_word_t       wr_mem_addr_q, // data memory write address
    output logic             s_ptr_en_q,    // source pointer update
    output rlcu_word_t       s_ptr_val_q,   // new source pointer
    output logic             d_ptr_en_q,    // destination ptr update
    output rlcu_word_t       d_ptr_val_q,   // new destination pointer
    output rlcu_word_t       sr_out_q       // status word after op
);
    // ****************************************************
    // decode
    // ****************************************************
    rlcu_form_t  form;
    rlcu_amode_t s_mode;
    rlcu_amode_t d_mode;
    rlcu_word_t  step;
    rlcu_word_t  s_ea;
    rlcu_word_t  d_ea;
    rlcu_word_t  s_ptr_new;
    rlcu_word_t  d_ptr_new;
    rlcu_word_t  opnd;
    rlcu_word_t  rot;
    logic [12:0] faddr;
    logic        byte_sel;
    logic        to_defw;
    logic        legal;
    logic        c_new;
    logic        n_new;
    logic        z_new;

    // opcode match decides the form; anything else is ignored
    always_comb
    begin
        form = RLCU_FORM_NONE;
        if (instr_word[`RLCU_F_OPHI] == `RLCU_OPC_HI &&
            instr_word[`RLCU_F_SEL] == `RLCU_OPC_SEL)
        begin
            if (instr_word[`RLCU_F_OPLO] == `RLCU_OPC_FILE)    // RL6
                form = RLCU_FORM_FILE;
            else if (instr_word[`RLCU_F_OPLO] == `RLCU_OPC_WFORM) // RL8
                form = RLCU_FORM_WFORM;
        end
    end

    // width bit as set by the assembler: suffix .b gives byte
    assign byte_sel = (instr_word[`RLCU_F_BYTE] ==
                       `RLCU_WIDTH_BYTE);                       // RL5 RL11
    assign to_defw  = (instr_word[`RLCU_F_DEST] == `RLCU_DEST_DEFW);  // RL4
    assign faddr    = instr_word[`RLCU_F_FADDR];                      // RL7
    assign s_mode   = instr_word[`RLCU_F_SMODE];                      // RL8
    assign d_mode   = instr_word[`RLCU_F_DMODE];                      // RL8
    assign reg_s_idx = instr_word[`RLCU_F_SREG];
    assign reg_d_idx = instr_word[`RLCU_F_DREG];
    assign step = byte_sel ? `RLCU_STEP_BYTE : `RLCU_STEP_WORD;

    // mode codes 6 and 7 are undefined; such words retire nothing
    assign legal = (form == RLCU_FORM_FILE) ||
                   (form == RLCU_FORM_WFORM &&
                    s_mode <= `RLCU_AM_PREINC &&
                    d_mode <= `RLCU_AM_PREINC);

    // ****************************************************
    // effective address and pointer arithmetic
    // ****************************************************
    function automatic rlcu_word_t ea_of(input rlcu_amode_t m,
                                         input rlcu_word_t  p,
                                         input rlcu_word_t  s);
        case (m)
            `RLCU_AM_PREDEC: ea_of = p - s;
            `RLCU_AM_PREINC: ea_of = p + s;
            default:         ea_of = p;
        endcase
    endfunction : ea_of

    function automatic rlcu_word_t ptr_of(input rlcu_amode_t m,
                                          input rlcu_word_t  p,
                                          input rlcu_word_t  s);
        case (m)
            `RLCU_AM_POSTDEC,
            `RLCU_AM_PREDEC:  ptr_of = p - s;
            `RLCU_AM_POSTINC,
            `RLCU_AM_PREINC:  ptr_of = p + s;
            default:          ptr_of = p;
        endcase
    endfunction : ptr_of

    // pre modes move the pointer before use, post modes after
    assign s_ea      = ea_of(s_mode, reg_s_val, step);          // RL14
    assign d_ea      = ea_of(d_mode, reg_d_val, step);          // RL14
    assign s_ptr_new = ptr_of(s_mode, reg_s_val, step);         // RL14
    assign d_ptr_new = ptr_of(d_mode, reg_d_val, step);         // RL14

    // operand fetch: memory for file form and indirect source
    always_comb
    begin
        mem_rd_en   = 1'b0;
        mem_rd_addr = {`RLCU_FADDR_PAD, faddr};
        opnd        = mem_rd_data;
        if (instr_valid && legal)
        begin
            if (form == RLCU_FORM_FILE)
                mem_rd_en = 1'b1;                               // RL7
            else if (s_mode == `RLCU_AM_DIR)
                opnd = reg_s_val;                               // RL14
            else
            begin
                mem_rd_en   = 1'b1;
                mem_rd_addr = s_ea;                             // RL14
            end
        end
    end

    // ****************************************************
    // rotation datapath
    // ****************************************************
    rlcu_rotator #(
        .W         (16)
    ) u_rot (
        .opnd      (opnd),
        .carry_in  (sr_in[`RLCU_SR_C]),                         // RL12
        .byte_sel  (byte_sel),
        .result    (rot),
        .carry_out (c_new),
        .neg       (n_new),
        .zero      (z_new)
    );

    // ****************************************************
    // one-cycle retire: all results land on the next edge
    // ****************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            done_q    <= 1'b0;
            wr_byte_q <= 1'b0;
            wr_data_q <= 16'h0000;
        end
        else
        begin
            done_q    <= instr_valid && legal;                  // RL10
            wr_byte_q <= byte_sel;
            wr_data_q <= rot;                                   // RL1 RL12
        end
    end

    // destination routing for both forms
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_reg_en_q   <= 1'b0;
            wr_reg_idx_q  <= 4'h0;
            wr_mem_en_q   <= 1'b0;
            wr_mem_addr_q <= 16'h0000;
        end
        else
        begin
            wr_reg_en_q <= 1'b0;
            wr_mem_en_q <= 1'b0;
            if (instr_valid && legal && form == RLCU_FORM_FILE)
            begin
                wr_reg_en_q   <= to_defw;                       // RL3 RL4
                wr_reg_idx_q  <= `RLCU_DEFW_IDX;                // RL3
                wr_mem_en_q   <= !to_defw;                      // RL3 RL4
                wr_mem_addr_q <= {`RLCU_FADDR_PAD, faddr};      // RL3
            end
            else if (instr_valid && legal)
            begin
                wr_reg_en_q   <= (d_mode == `RLCU_AM_DIR);      // RL14
                wr_reg_idx_q  <= reg_d_idx;
                wr_mem_en_q   <= (d_mode != `RLCU_AM_DIR);      // RL14
                wr_mem_addr_q <= d_ea;
            end
        end
    end

    // pointer write-backs; if source and destination name the
    // same register the core must give the destination priority
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_ptr_en_q  <= 1'b0;
            s_ptr_val_q <= 16'h0000;
            d_ptr_en_q  <= 1'b0;
            d_ptr_val_q <= 16'h0000;
        end
        else
        begin
            s_ptr_en_q  <= instr_valid && legal &&
                           form == RLCU_FORM_WFORM &&
                           s_mode >= `RLCU_AM_POSTDEC;          // RL14
            s_ptr_val_q <= s_ptr_new;
            d_ptr_en_q  <= instr_valid && legal &&
                           form == RLCU_FORM_WFORM &&
                           d_mode >= `RLCU_AM_POSTDEC;          // RL14
            d_ptr_val_q <= d_ptr_new;
        end
    end

    // status word: only N, Z, C are replaced, rest copied through
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sr_out_q <= `RLCU_SR_RST;
        else if (instr_valid && legal)
        begin
            sr_out_q              <= sr_in;                     // RL9
            sr_out_q[`RLCU_SR_C]  <= c_new;                     // RL2
            sr_out_q[`RLCU_SR_Z]  <= z_new;                     // RL13
            sr_out_q[`RLCU_SR_N]  <= n_new;                     // RL13
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_issue;
        instr_valid && legal;
    endsequence
    sequence s_file_issue;
        instr_valid && form == RLCU_FORM_FILE;
    endsequence

    chk_retire_one: assert property (s_issue |=> done_q) // RL10
        else $error("legal instruction did not retire next cycle");
    chk_no_retire: assert property (!(instr_valid && legal) |=> !done_q) // RL10
        else $error("retire without a legal instruction");
    chk_carry_in_lsb: assert property (s_issue |=>
            wr_data_q[0] == $past(sr_in[`RLCU_SR_C])) // RL1
        else $error("old carry not placed in bit 0");
    chk_word_shift: assert property (s_issue ##0 !byte_sel |=>
            wr_data_q[15:1] == $past(opnd[14:0])) // RL1
        else $error("word rotation body wrong");
    chk_carry_out: assert property (s_issue |=>
            sr_out_q[`RLCU_SR_C] ==
            ($past(byte_sel) ? $past(opnd[7]) : $past(opnd[15]))) // RL2
        else $error("carry not taken from old top bit");
    chk_dest_defw: assert property (s_file_issue ##0 to_defw |=>
            wr_reg_en_q && wr_reg_idx_q == `RLCU_DEFW_IDX &&
            !wr_mem_en_q) // RL3
        else $error("default register not written");
    chk_dest_file: assert property (s_file_issue ##0 !to_defw |=>
            wr_mem_en_q && !wr_reg_en_q &&
            wr_mem_addr_q[12:0] == $past(faddr)) // RL4
        else $error("file register not written back");
    chk_other_bits: assert property (s_issue |=>
            (sr_out_q & ~`RLCU_FLAG_MASK) ==
            ($past(sr_in) & ~`RLCU_FLAG_MASK)) // RL9
        else $error("status bits outside N Z C changed");
    chk_neg_zero: assert property (done_q |->
            sr_out_q[`RLCU_SR_N] ==
            (wr_byte_q ? wr_data_q[7] : wr_data_q[15]) &&
            sr_out_q[`RLCU_SR_Z] == (wr_byte_q ?
            wr_data_q[7:0] == 8'h00 : wr_data_q == 16'h0000)) // RL13
        else $error("negative or zero flag wrong");
    chk_post_inc: assert property (s_issue ##0
            form == RLCU_FORM_WFORM && s_mode == `RLCU_AM_POSTINC |=>
            s_ptr_en_q && s_ptr_val_q ==
            $past(reg_s_val) + $past(step)) // RL14
        else $error("post increment pointer wrong");
endmodule : rlcu_top

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top
    import rlcu_pkg::*;
;
    logic        clk, arst_n, instr_valid, mem_rd_en, done_q, wr_byte_q;
    logic        wr_reg_en_q, wr_mem_en_q, s_ptr_en_q, d_ptr_en_q;
    logic [23:0] instr_word;
    logic [3:0]  reg_s_idx, reg_d_idx, wr_reg_idx_q;
    rlcu_word_t  sr_in, reg_s_val, reg_d_val, mem_rd_data, mem_rd_addr;
    rlcu_word_t  wr_data_q, wr_mem_addr_q, s_ptr_val_q, d_ptr_val_q;
    rlcu_word_t  sr_out_q, sr_exp;
    int          miscompares, n_tests, cycles;

    rlcu_top uut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .sr_in(sr_in), .reg_s_val(reg_s_val),
        .reg_d_val(reg_d_val), .mem_rd_data(mem_rd_data),
        .reg_s_idx(reg_s_idx), .reg_d_idx(reg_d_idx),
        .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .done_q(done_q),
        .wr_byte_q(wr_byte_q), .wr_data_q(wr_data_q),
        .wr_reg_en_q(wr_reg_en_q), .wr_reg_idx_q(wr_reg_idx_q),
        .wr_mem_en_q(wr_mem_en_q), .wr_mem_addr_q(wr_mem_addr_q),
        .s_ptr_en_q(s_ptr_en_q), .s_ptr_val_q(s_ptr_val_q),
        .d_ptr_en_q(d_ptr_en_q), .d_ptr_val_q(d_ptr_val_q),
        .sr_out_q(sr_out_q));

    rlcu_core_model model (.reg_s_idx(reg_s_idx), .reg_d_idx(reg_d_idx),
        .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
        .reg_s_val(reg_s_val), .reg_d_val(reg_d_val),
        .mem_rd_data(mem_rd_data));

    // ********************************************************
    // clock, hang guard and helpers
    // ********************************************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // whole run needs well under a hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            close_out;
        end
    end

    task automatic close_out;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_b

    // reference rotation, kept apart from the design's own logic
    function automatic logic [15:0] rl(input logic [15:0] v,
                                       input logic c, input logic b);
        return b ? {v[15:8], v[6:0], c} : {v[14:0], c};
    endfunction : rl

    function automatic logic [15:0] sr_after(input logic [15:0] v,
                                             input logic [15:0] sr,
                                             input logic b);
        logic [15:0] r;
        logic [15:0] s;
        r    = rl(v, sr[0], b);
        s    = sr & ~16'h000B;
        s[0] = b ? v[7] : v[15];
        s[1] = b ? (r[7:0] == 8'h00) : (r == 16'h0000);
        s[3] = b ? r[7] : r[15];
        return s;
    endfunction : sr_after

    // effective address per addressing mode, new pointer for modes 2 to 5 only
    function automatic logic [15:0] ea(input logic [15:0] p,
                                       input logic [2:0] m,
                                       input logic [15:0] st);
        return (m == 3'h4) ? p - st : (m == 3'h5) ? p + st : p;
    endfunction : ea

    function automatic logic [15:0] pv(input logic [15:0] p,
                                       input logic [2:0] m,
                                       input logic [15:0] st);
        return (m == 3'h2 || m == 3'h4) ? p - st : p + st;
    endfunction : pv

    // lets one edge pass first, so a just-lowered valid is never raised
    // again in the same time step
    task automatic issue(input logic [23:0] w, input logic [15:0] sr);
        @(posedge clk);
        #2;
        instr_word  = w;
        sr_in       = sr;
        instr_valid = 1'b1;
    endtask : issue

    task automatic step;
        @(posedge clk);
        #2;
        instr_valid = 1'b0;
    endtask : step

    // one edge, then the common result checks of a retired instruction
    task automatic retire(input logic [15:0] op, input logic b);
        logic [15:0] sr;
        sr = sr_in;
        step;
        sr_exp = sr_after(op, sr, b);
        chk_b(done_q, 1'b1);
        chk_b(wr_byte_q, b);
        chk_w(wr_data_q, rl(op, sr[0], b));
        chk_w(sr_out_q, sr_exp);
    endtask : retire

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_file;
        model.mem[13'h1233] = 16'h3C80;
        model.mem[13'h1FFF] = 16'h8000;
        issue(24'hD6F233, 16'hF0F1);
        #1;
        chk_b(mem_rd_en, 1'b1);
        chk_w(mem_rd_addr, 16'h1233);
        retire(16'h3C80, 1'b1);
        chk_b(wr_reg_en_q, 1'b1);
        chk_b(wr_mem_en_q, 1'b0);
        chk_w({12'h000, wr_reg_idx_q}, 16'h0000);
        step;
        chk_b(done_q, 1'b0);
        issue(24'hD69FFF, 16'h0000);
        #1;
        chk_w(mem_rd_addr, 16'h1FFF);
        retire(16'h8000, 1'b0);
        chk_b(wr_mem_en_q, 1'b1);
        chk_b(wr_reg_en_q, 1'b0);
        chk_w(wr_mem_addr_q, 16'h1FFF);
        chk_w(sr_out_q, 16'h0003);
    endtask : t_file

    task automatic t_modes;
        logic [2:0]  m;
        logic        b;
        logic [15:0] st, es, ed, op;
        for (int k = 16'h00FC; k <= 16'h0104; k++)
            model.mem[k] = {k[7:0], 8'h81};
        model.regs[2] = 16'h0100;
        model.regs[8] = 16'h0200;
        for (int i = 0; i < 12; i++)
        begin
            m  = 3'(i % 6);
            b  = (i >= 6);
            st = b ? 16'h0001 : 16'h0002;
            es = ea(16'h0100, m, st);
            ed = ea(16'h0200, m, st);
            op = (m == 3'h0) ? 16'h0100 : model.mem[es[12:0]];
            issue({8'hD2, 1'b1, b, m, 4'h8, m, 4'h2}, 16'h0001);
            #1;
            chk_b(mem_rd_en, m != 3'h0);
            if (m != 3'h0)
                chk_w(mem_rd_addr, es);
            retire(op, b);
            chk_b(wr_reg_en_q, m == 3'h0);
            chk_b(wr_mem_en_q, m != 3'h0);
            if (m == 3'h0)
                chk_w({12'h000, wr_reg_idx_q}, 16'h0008);
            else
                chk_w(wr_mem_addr_q, ed);
            chk_b(s_ptr_en_q, m >= 3'h2);
            chk_b(d_ptr_en_q, m >= 3'h2);
            if (m >= 3'h2)
            begin
                chk_w(s_ptr_val_q, pv(16'h0100, m, st));
                chk_w(d_ptr_val_q, pv(16'h0200, m, st));
            end
        end
    endtask : t_modes

    task automatic t_refuse;
        logic [23:0] bad [3];
        bad = '{24'hD2C062, 24'hD28072, 24'hD7F233};
        foreach (bad[i])
        begin
            issue(bad[i], 16'h000F);
            #1;
            chk_b(mem_rd_en, 1'b0);
            step;
            chk_b(done_q, 1'b0);
            chk_b(wr_reg_en_q, 1'b0);
            chk_b(wr_mem_en_q, 1'b0);
            chk_w(sr_out_q, sr_exp);
        end
    endtask : t_refuse

    task automatic t_b2b;
        issue(24'hD6F233, 16'h0001);
        @(posedge clk);
        #2;
        instr_word = 24'hD69FFF;
        sr_in      = 16'h0000;
        chk_b(done_q, 1'b1);
        chk_w(wr_data_q, 16'h3C01);
        retire(16'h8000, 1'b0);
    endtask : t_b2b

    // ********************************************************
    // main sequence
    // ********************************************************
    initial
    begin
        arst_n      = 1'b0;
        instr_valid = 1'b0;
        instr_word  = 24'h000000;
        sr_in       = 16'h0000;
        sr_exp      = 16'h0000;
        repeat (4) @(posedge clk);
        #2;
        arst_n = 1'b1;
        chk_b(done_q, 1'b0);
        chk_w(sr_out_q, 16'h0000);
        t_file;
        t_modes;
        t_refuse;
        t_b2b;
        step;
        close_out;
    end
endmodule : tb_top

`default_nettype wire
